// ===== hdl/pmc_power_mode_controller.sv
// Power mode state controller
`include "pmc_defs.svh"
module pmc_power_mode_controller #(
   parameter int unsigned STARTUP_CYC = `PMC_STARTUP_CYC,
   parameter bit STACK_DEVICE = 1'b0
)(
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   input wire logic i_wake_pin_n,
   input wire logic i_uart_s2a,
   input wire logic i_chain_wake_tone,
   input wire logic i_chain_s2a_tone,
   input wire logic i_sleep_request,
   input wire logic i_shutdown_request,
   input wire logic i_thermal_shutdown_event,
   input wire logic i_valid_frame,
   input wire logic i_long_idle_timeout_en,
   input wire logic [`PMC_IDLE_CNT_W-1:0] i_long_idle_limit,
   input wire logic i_soft_reset_cmd,
   input wire logic i_reset_flag_clear,
   input wire logic i_osc_fault_event,
   input wire logic i_osc_fault_clear,
   input wire logic i_comp_fault_en,
   input wire logic i_fault_pending,
   output pmc_pkg::pmc_mode_t o_mode,
   output logic o_restore_defaults,
   output logic o_fwd_wake,
   output logic o_fwd_s2a,
   output logic o_discard_txn,
   output logic o_startup_done,
   output logic o_reset_occurred_flag,
   output logic o_digital_supply_osc_fault,
   output logic o_fault_out_n,
   output logic o_heartbeat_run,
   output logic o_comp_fault_run,
   output logic o_balance_run,
   output logic o_sleep_detect_run,
   output logic o_comm_run
);
   import pmc_pkg::*;

   pmc_mode_t mode_reg;
   pmc_mode_t mode_next;
   logic wake_m_reg;
   logic wake_s_reg;
   logic wake_d_reg;
   logic uart_m_reg;
   logic uart_s_reg;
   logic wtone_m_reg;
   logic wtone_s_reg;
   logic stone_m_reg;
   logic stone_s_reg;
   logic tsd_m_reg;
   logic tsd_s_reg;
   logic wake_ev;
   logic s2a_ev;
   logic idle_to;
   logic sd_cause;
   logic comp_lock_reg;
   logic [`PMC_IDLE_CNT_W-1:0] idle_cnt_reg;
   logic [31:0] su_cnt_reg;
   logic uart_d_reg;
   logic wtone_d_reg;
   logic stone_d_reg;
   logic tsd_d_reg;
   logic tsd_rise;
   logic wake_ok;
   logic s2a_ok;

   // Rising edge of a synchronised level
   function automatic logic rise(input logic now_lvl, input logic last_lvl);
      return now_lvl & ~last_lvl;
   endfunction

   // Wake pin passes two flops, idles high
   always_ff @(posedge i_clk_sys)
   begin
      if (!i_rst_n)
      begin
         wake_m_reg <= 1'b1;
         wake_s_reg <= 1'b1;
         wake_d_reg <= 1'b1;
      end
      else
      begin
         wake_m_reg <= i_wake_pin_n;
         wake_s_reg <= wake_m_reg;
         wake_d_reg <= wake_s_reg;
      end
   end

   // UART detect and chain tones pass two flops
   always_ff @(posedge i_clk_sys)
   begin
      if (!i_rst_n)
      begin
         uart_m_reg <= 1'b0;
         uart_s_reg <= 1'b0;
         wtone_m_reg <= 1'b0;
         wtone_s_reg <= 1'b0;
         stone_m_reg <= 1'b0;
         stone_s_reg <= 1'b0;
      end
      else
      begin
         uart_m_reg <= i_uart_s2a;
         uart_s_reg <= uart_m_reg;
         wtone_m_reg <= i_chain_wake_tone;
         wtone_s_reg <= wtone_m_reg;
         stone_m_reg <= i_chain_s2a_tone;
         stone_s_reg <= stone_m_reg;
      end
   end

   // Thermal event passes two flops
   always_ff @(posedge i_clk_sys)
   begin
      if (!i_rst_n)
      begin
         tsd_m_reg <= 1'b0;
         tsd_s_reg <= 1'b0;
      end
      else
      begin
         tsd_m_reg <= i_thermal_shutdown_event;
         tsd_s_reg <= tsd_m_reg;
      end
   end

   // Last value of the UART, chain tone and thermal levels, so a held level acts once
   always_ff @(posedge i_clk_sys)
   begin
      if (!i_rst_n)
      begin
         uart_d_reg <= 1'b0;
         wtone_d_reg <= 1'b0;
         stone_d_reg <= 1'b0;
         tsd_d_reg <= 1'b0;
      end
      else
      begin
         uart_d_reg <= uart_s_reg;
         wtone_d_reg <= wtone_s_reg;
         stone_d_reg <= stone_s_reg;
         tsd_d_reg <= tsd_s_reg;
      end
   end

   assign tsd_rise = rise(tsd_s_reg, tsd_d_reg);

   // Base uses pin and UART, stack uses chain tones
   always_comb
   begin
      if (STACK_DEVICE)
      begin
         wake_ev = rise(wtone_s_reg, wtone_d_reg);
         s2a_ev = rise(stone_s_reg, stone_d_reg);
      end
      else
      begin
         wake_ev = rise(wake_s_reg, wake_d_reg);
         s2a_ev = rise(uart_s_reg, uart_d_reg);
      end
   end

   // Idle timer runs only in active
   always_ff @(posedge i_clk_sys)
   begin
      if (!i_rst_n || mode_reg != PMC_ACTIVE || i_valid_frame)
         idle_cnt_reg <= '0;
      else if (idle_cnt_reg != i_long_idle_limit)
         idle_cnt_reg <= idle_cnt_reg + 1'b1;
   end

   assign idle_to = i_long_idle_timeout_en && mode_reg == PMC_ACTIVE
      && idle_cnt_reg == i_long_idle_limit;
   assign sd_cause = tsd_s_reg | i_shutdown_request | idle_to;

   always_comb
   begin
      mode_next = mode_reg;
      unique case (mode_reg)
         PMC_SHUTDOWN:
         begin
            if (wake_ev)
               mode_next = PMC_ACTIVE;
         end
         PMC_SLEEP:
         begin
            if (tsd_s_reg || i_shutdown_request)
               mode_next = PMC_SHUTDOWN;
            else if (wake_ev || s2a_ev)
               mode_next = PMC_ACTIVE;
         end
         PMC_ACTIVE:
         begin
            if (sd_cause)
               mode_next = PMC_SHUTDOWN;
            else if (i_sleep_request)
               mode_next = PMC_SLEEP;
         end
         default:
            mode_next = PMC_SHUTDOWN;
      endcase
   end

   always_ff @(posedge i_clk_sys)
   begin
      if (!i_rst_n)
         mode_reg <= PMC_SHUTDOWN;
      else if (tsd_s_reg)
         mode_reg <= PMC_SHUTDOWN;
      else
         mode_reg <= mode_next;
   end

   // Wake is honoured unless thermal wins this cycle, or, in active only, any shutdown cause wins
   assign wake_ok = wake_ev && !tsd_s_reg && (mode_reg != PMC_ACTIVE || !sd_cause);
   assign s2a_ok = s2a_ev && !wake_ev && !tsd_s_reg && mode_reg == PMC_ACTIVE && !sd_cause;

   // Defaults restored on every honoured wake
   always_ff @(posedge i_clk_sys)
   begin
      if (!i_rst_n)
         o_restore_defaults <= 1'b0;
      else
         o_restore_defaults <= wake_ok;
   end

   // Wake forwarded only from active
   always_ff @(posedge i_clk_sys)
   begin
      if (!i_rst_n)
         o_fwd_wake <= 1'b0;
      else
         o_fwd_wake <= wake_ok && mode_reg == PMC_ACTIVE;
   end

   // Sleep-to-active forwarded from active, nothing else changes
   always_ff @(posedge i_clk_sys)
   begin
      if (!i_rst_n)
         o_fwd_s2a <= 1'b0;
      else
         o_fwd_s2a <= s2a_ok;
   end

   // One discard pulse per thermal event
   always_ff @(posedge i_clk_sys)
   begin
      if (!i_rst_n)
         o_discard_txn <= 1'b0;
      else
         o_discard_txn <= tsd_rise;
   end

   // Startup wait after entering active
   always_ff @(posedge i_clk_sys)
   begin
      if (!i_rst_n || mode_reg != PMC_ACTIVE)
         su_cnt_reg <= '0;
      else if (su_cnt_reg != STARTUP_CYC)
         su_cnt_reg <= su_cnt_reg + 1'b1;
   end
   assign o_startup_done = mode_reg == PMC_ACTIVE && su_cnt_reg == STARTUP_CYC;

   // Reset flag, set wins over clear
   always_ff @(posedge i_clk_sys)
   begin
      if (!i_rst_n)
         o_reset_occurred_flag <= 1'b1;
      else if (i_soft_reset_cmd || (wake_ok && mode_reg != PMC_SLEEP))
         o_reset_occurred_flag <= 1'b1;
      else if (i_reset_flag_clear)
         o_reset_occurred_flag <= 1'b0;
   end

   always_ff @(posedge i_clk_sys)
   begin
      if (!i_rst_n)
         o_digital_supply_osc_fault <= 1'b0;
      else if (i_osc_fault_event)
         o_digital_supply_osc_fault <= 1'b1;
      else if (i_osc_fault_clear)
         o_digital_supply_osc_fault <= 1'b0;
   end

   // Comparator enable latched; frozen outside active except for the clear on a restore-defaults pulse
   always_ff @(posedge i_clk_sys)
   begin
      if (!i_rst_n || o_restore_defaults)
         comp_lock_reg <= 1'b0;
      else if (mode_reg == PMC_ACTIVE)
         comp_lock_reg <= i_comp_fault_en;
   end

   always_comb
   begin
      o_mode = mode_reg;
      o_comm_run = mode_reg == PMC_ACTIVE;
      o_balance_run = mode_reg != PMC_SHUTDOWN;
      o_sleep_detect_run = mode_reg != PMC_SHUTDOWN;
      o_comp_fault_run = comp_lock_reg && mode_reg != PMC_SHUTDOWN;
      o_heartbeat_run = mode_reg != PMC_SHUTDOWN && !o_reset_occurred_flag;
      o_fault_out_n = !(mode_reg != PMC_SHUTDOWN && (o_reset_occurred_flag
         || o_digital_supply_osc_fault || i_fault_pending));
   end
endmodule // pmc_power_mode_controller

// ===== inc/pmc_defs.svh
// Constants for the power mode controller
`ifndef PMC_DEFS_SVH
`define PMC_DEFS_SVH
`define PMC_IDLE_CNT_W 32
`define PMC_IDLE_LIMIT_RST 32'h0000_1000
`define PMC_STARTUP_US 1
`define PMC_CLK_MHZ 20
`define PMC_STARTUP_CYC (((`PMC_STARTUP_US * `PMC_CLK_MHZ) > 0) ? (`PMC_STARTUP_US * `PMC_CLK_MHZ) : 1)
`endif

// ===== inc/pmc_pkg.sv
// Types for the power mode controller
package pmc_pkg;
   typedef enum logic [1:0]
   {
      PMC_SHUTDOWN = 2'b00,
      PMC_SLEEP = 2'b01,
      PMC_ACTIVE = 2'b10
   } pmc_mode_t;
endpackage

// ===== verif/pmc_mode_sva.sv
// Assertion checker for the power mode controller
module pmc_mode_sva
   import pmc_pkg::*;
(
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   input wire logic i_wake_pin_n,
   input wire logic i_uart_s2a,
   input wire logic i_sleep_request,
   input wire logic i_shutdown_request,
   input wire logic i_thermal_shutdown_event,
   input wire logic i_long_idle_timeout_en,
   input pmc_pkg::pmc_mode_t o_mode,
   input wire logic o_restore_defaults,
   input wire logic o_fwd_wake,
   input wire logic o_discard_txn,
   input wire logic o_reset_occurred_flag,
   input wire logic o_fault_out_n,
   input wire logic o_comp_fault_run
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (!i_rst_n);
   wire calm = !i_shutdown_request && !i_thermal_shutdown_event;
   sequence s_pin_release;
      $rose(i_wake_pin_n) && calm;
   endsequence
   sequence s_sleep_s2a;
      o_mode == PMC_SLEEP && $rose(i_uart_s2a) && i_wake_pin_n && calm;
   endsequence
   a_sleep_entry: assert property (o_mode == PMC_ACTIVE && i_sleep_request && calm
      && !i_long_idle_timeout_en |=> o_mode == PMC_SLEEP) else $error("sleep request not taken");
   a_sd_request: assert property (i_shutdown_request |=> o_mode == PMC_SHUTDOWN)
      else $error("shutdown request not taken");
   a_thermal_off: assert property (i_thermal_shutdown_event |-> ##[1:3] o_mode == PMC_SHUTDOWN)
      else $error("thermal event did not shut down");
   a_quiet_discard: assert property (o_discard_txn |-> o_mode == PMC_SHUTDOWN && o_fault_out_n)
      else $error("discard without silent shutdown");
   a_comp_locked: assert property (o_mode == PMC_SLEEP && $past(o_mode) == PMC_SLEEP
      |-> $stable(o_comp_fault_run)) else $error("comparators changed in sleep");
   a_sd_wake: assert property ((o_mode == PMC_SHUTDOWN) ##0 s_pin_release
      |-> ##[1:4] o_mode == PMC_ACTIVE) else $error("wake from shutdown missed");
   a_s2a_resume: assert property (s_sleep_s2a |-> ##[1:3]
      ($changed(o_mode) && o_mode == PMC_ACTIVE && !o_restore_defaults)) else $error("bad sleep resume");
   a_wake_reset: assert property ((o_mode == PMC_ACTIVE) ##0 s_pin_release |->
      ##[1:4] (o_restore_defaults && o_fwd_wake) ##[0:1] o_reset_occurred_flag) else $error("active wake wrong");
endmodule // pmc_mode_sva
bind pmc_power_mode_controller pmc_mode_sva i_sva (.i_clk_sys, .i_rst_n, .i_wake_pin_n, .i_uart_s2a,
   .i_sleep_request, .i_shutdown_request, .i_thermal_shutdown_event, .i_long_idle_timeout_en, .o_mode,
   .o_restore_defaults, .o_fwd_wake, .o_discard_txn, .o_reset_occurred_flag, .o_fault_out_n, .o_comp_fault_run);

// ===== verif/pmc_host_model.sv
// Host model driving the wake pin and the UART sleep-to-active detect
module pmc_host_model
(
   input wire logic i_clk_sys,
   output logic o_wake_pin_n = 1'b1,
   output logic o_uart_s2a = 1'b0
);
   timeunit 1ns;
   timeprecision 1ns;
   task automatic send(input bit wake);
      @(negedge i_clk_sys);
      if (wake)
         o_wake_pin_n = 1'b0;
      else
         o_uart_s2a = 1'b1;
      repeat (3) @(negedge i_clk_sys);
      o_wake_pin_n = 1'b1;
      o_uart_s2a = 1'b0;
   endtask
endmodule // pmc_host_model

// ===== verif/pmc_power_mode_controller_tb_top.sv
// Testbench for the power mode controller
module pmc_power_mode_controller_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import pmc_pkg::*;
   localparam logic [6:0] SLP = 7'h01, SDN = 7'h02, CLR = 7'h04, SRST = 7'h08, OFE = 7'h10, OFC = 7'h20;
   localparam logic [6:0] VF = 7'h40;
   logic i_clk_sys = 1'b0;
   logic i_rst_n = 1'b0;
   logic [6:0] req = 7'h00;
   logic i_thermal_shutdown_event = 1'b0;
   logic i_long_idle_timeout_en = 1'b0;
   logic i_comp_fault_en = 1'b0;
   logic i_fault_pending = 1'b0;
   logic [31:0] idle_limit = 32'h0000_0008;
   logic o_heartbeat_run, o_sleep_detect_run;
   logic i_wake_pin_n, i_uart_s2a, o_restore_defaults, o_fwd_wake, o_fwd_s2a, o_discard_txn, o_startup_done;
   logic o_reset_occurred_flag, o_digital_supply_osc_fault, o_fault_out_n, o_comp_fault_run, o_balance_run;
   logic o_comm_run;
   pmc_mode_t o_mode;
   int err_count = 0, check_count = 0, n_rd = 0, n_fw = 0, n_fs = 0, n_dc = 0;
   initial forever #25 i_clk_sys = ~i_clk_sys;
   // Tally of one-cycle pulses
   always @(posedge i_clk_sys)
   begin
      n_rd += int'(o_restore_defaults === 1'b1);
      n_fw += int'(o_fwd_wake === 1'b1);
      n_fs += int'(o_fwd_s2a === 1'b1);
      n_dc += int'(o_discard_txn === 1'b1);
   end
   pmc_power_mode_controller #(.STARTUP_CYC(4), .STACK_DEVICE(1'b0)) i_dut (.i_clk_sys, .i_rst_n,
      .i_wake_pin_n, .i_uart_s2a, .i_chain_wake_tone(1'b0), .i_chain_s2a_tone(1'b0), .i_sleep_request(req[0]),
      .i_shutdown_request(req[1]), .i_thermal_shutdown_event, .i_valid_frame(req[6]), .i_long_idle_timeout_en,
      .i_long_idle_limit(idle_limit), .i_soft_reset_cmd(req[3]), .i_reset_flag_clear(req[2]),
      .i_osc_fault_event(req[4]), .i_osc_fault_clear(req[5]), .i_comp_fault_en, .i_fault_pending,
      .o_mode, .o_restore_defaults, .o_fwd_wake, .o_fwd_s2a, .o_discard_txn, .o_startup_done,
      .o_reset_occurred_flag, .o_digital_supply_osc_fault, .o_fault_out_n, .o_heartbeat_run,
      .o_comp_fault_run, .o_balance_run, .o_sleep_detect_run, .o_comm_run);
   pmc_host_model i_host (.i_clk_sys, .o_wake_pin_n(i_wake_pin_n), .o_uart_s2a(i_uart_s2a));
   task automatic wt(input int n);
      repeat (n) @(negedge i_clk_sys);
   endtask
   task automatic pulse(input logic [6:0] m);
      @(negedge i_clk_sys);
      req = m;
      @(negedge i_clk_sys);
      req = 7'h00;
   endtask
   task automatic chk_bit(input string nm, input logic exp, input logic got);
      check_count++;
      err_count += int'(got !== exp);
      if (got !== exp)
         $display("Error %s expected %b seen %b", nm, exp, got);
   endtask
   task automatic chk_mode(input pmc_mode_t exp);
      chk_bit("mode high", exp[1], o_mode[1]);
      chk_bit("mode low", exp[0], o_mode[0]);
   endtask
   task automatic stop_test;
      $display("Checks %0d errors %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   initial
   begin
      repeat (1000) @(posedge i_clk_sys);
      err_count++;
      stop_test();
   end
   initial
   begin
      wt(2);
      i_rst_n = 1'b1;
      chk_mode(PMC_SHUTDOWN);
      i_host.send(1'b1);
      wt(7);
      chk_mode(PMC_ACTIVE);
      chk_bit("reset flag", 1'b1, o_reset_occurred_flag);
      chk_bit("startup done", 1'b1, o_startup_done);
      pulse(CLR);
      chk_bit("reset flag", 1'b0, o_reset_occurred_flag);
      chk_bit("fault out", 1'b1, o_fault_out_n);
      chk_bit("heartbeat", 1'b1, o_heartbeat_run);
      i_fault_pending = 1'b1;
      wt(1);
      chk_bit("fault out", 1'b0, o_fault_out_n);
      i_fault_pending = 1'b0;
      pulse(OFE);
      chk_bit("osc fault", 1'b1, o_digital_supply_osc_fault);
      pulse(OFC);
      chk_bit("osc fault", 1'b0, o_digital_supply_osc_fault);
      i_comp_fault_en = 1'b1;
      pulse(SLP);
      chk_mode(PMC_SLEEP);
      chk_bit("comp run", 1'b1, o_comp_fault_run);
      chk_bit("balance run", 1'b1, o_balance_run);
      chk_bit("comm run", 1'b0, o_comm_run);
      chk_bit("sleep detect", 1'b1, o_sleep_detect_run);
      i_comp_fault_en = 1'b0;
      wt(2);
      chk_bit("comp run", 1'b1, o_comp_fault_run);
      i_host.send(1'b0);
      wt(5);
      chk_mode(PMC_ACTIVE);
      chk_bit("restore count", 1'b1, n_rd == 1);
      chk_bit("comp run", 1'b0, o_comp_fault_run);
      chk_bit("comm run", 1'b1, o_comm_run);
      n_fs = 0;
      i_host.send(1'b0);
      wt(5);
      chk_mode(PMC_ACTIVE);
      chk_bit("forward s2a", 1'b1, n_fs == 1 && n_rd == 1);
      pulse(SLP);
      i_host.send(1'b1);
      wt(6);
      chk_mode(PMC_ACTIVE);
      chk_bit("restore count", 1'b1, n_rd == 2);
      n_fw = 0;
      i_host.send(1'b1);
      wt(6);
      chk_bit("wake fwd", 1'b1, n_rd == 3 && n_fw == 1);
      chk_bit("reset flag", 1'b1, o_reset_occurred_flag);
      pulse(CLR);
      pulse(SRST);
      chk_bit("reset flag", 1'b1, o_reset_occurred_flag);
      pulse(SLP | SDN);
      chk_mode(PMC_SHUTDOWN);
      i_host.send(1'b1);
      wt(6);
      i_long_idle_timeout_en = 1'b1;
      wt(2);
      pulse(VF);
      wt(4);
      chk_mode(PMC_ACTIVE);
      wt(8);
      chk_mode(PMC_SHUTDOWN);
      i_long_idle_timeout_en = 1'b0;
      i_host.send(1'b1);
      wt(6);
      i_thermal_shutdown_event = 1'b1;
      wt(4);
      chk_mode(PMC_SHUTDOWN);
      chk_bit("discard", 1'b1, n_dc == 1 && o_fault_out_n === 1'b1);
      chk_bit("heartbeat", 1'b0, o_heartbeat_run);
      chk_bit("sleep detect", 1'b0, o_sleep_detect_run);
      i_thermal_shutdown_event = 1'b0;
      stop_test();
   end
endmodule // pmc_power_mode_controller_tb_top
